// ### csr_axi_lite_slave_port_test.sv
// self-checking bench of the csr port
`include "csra_map.svh"
module csr_axi_lite_slave_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, reset_n, irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [12:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, exp_scr, rv, dv;
  logic [3:0] s_axi_wstrb, st;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  int bad_count, comparisons, seed, cycles, pulses, i;
  localparam logic [1:0] okay = `CSRA_RESP_OKAY;
  localparam logic [1:0] dec = `CSRA_RESP_DECERR;
  localparam logic [12:0] scr = `CSRA_REG_SCR;
  csra_axil_port csra_axil_port_i (.*);
  csra_axil_master csra_axil_master_i (.*);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // hang guard; about 500 cycles are needed
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    pulses <= pulses + (irq === 1'b1);
    if (cycles == 6000) begin
      bad_count++;
      end_of_test();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // random bready delay and a random lead of the address over the data
  task w(input logic [12:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
    int dl, gp;
    dl = $random(seed) & 3;
    gp = $random(seed) & 3;
    csra_axil_master_i.wr(a, d, s, dl, gp, resp);
    chk({30'h0, resp}, {30'h0, e});
  endtask : w
  task r(input logic [12:0] a, input logic [31:0] e, input logic [1:0] er);
    csra_axil_master_i.rd(a, $random(seed) & 3, dv, resp);
    chk(dv, e);
    chk({30'h0, resp}, {30'h0, er});
  endtask : r
  // byte lanes taken only where the strobe is set
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
    for (int b = 0; b < 4; b++) o[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
    return o;
  endfunction : merge
  task end_of_test();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    {reset_n, seed, exp_scr} = {1'b0, 48, 32'h0};
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    r(`CSRA_REG_CTRL, `CSRA_CTRL_RST, okay);
    // random strobed writes, first two with no lane and all lanes
    for (i = 0; i < 40; i++) begin
      {rv, st} = {$random(seed), i == 1 ? 4'hf : (i == 0 ? 4'h0 : 4'($random(seed)))};
      w(scr, rv, st, okay);
      exp_scr = merge(exp_scr, rv, st);
      r(scr, exp_scr, okay);
    end
    // unmapped and read-only places refuse, scratch untouched
    w(13'h1ffc, rv, 4'hf, dec);
    w(`CSRA_REG_STAT, rv, 4'hf, dec);
    r(13'h0010, 32'h0, dec);
    r(scr, exp_scr, okay);
    // events: writes while enabled pulse irq, the enabling write does not
    w(`CSRA_REG_CTRL, 32'h1, 4'h1, okay);
    r(`CSRA_REG_STAT, 32'h1, okay);
    for (i = 0; i < 3; i++) w(scr, exp_scr, 4'hf, okay);
    w(`CSRA_REG_CTRL, 32'h0, 4'h1, okay);
    repeat (2) @(posedge sys_clk);
    chk(pulses, 32'h4);
    r(`CSRA_REG_EVT, 32'h4, okay);
    // reset in mid-run
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    r(scr, `CSRA_SCR_RST, okay);
    end_of_test();
  end
endmodule : csr_axi_lite_slave_port_test

// ### csra_axil_master.sv
// axi4-lite master model facing the csr port
module csra_axil_master (
  // clock
  input wire logic sys_clk,
  // master requests
  output logic [12:0] s_axi_awaddr,
  output logic [2:0] s_axi_awprot,
  output logic s_axi_awvalid,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  output logic s_axi_bready,
  output logic [12:0] s_axi_araddr,
  output logic [2:0] s_axi_arprot,
  output logic s_axi_arvalid,
  output logic s_axi_rready,
  // port answers
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle at time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_awprot, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {s_axi_araddr, s_axi_arprot} = 16'h0;
  end
  // address gap cycles ahead of the data, or together when gap is zero;
  // released address and data lines show the inverse, not the old value
  task wr(input logic [12:0] a, input logic [31:0] d, input logic [3:0] s, input int dly,
      input int gap, output logic [1:0] r);
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid} <= {a, d[2:0], 1'b1};
    if (gap > 0) begin
      do @(posedge sys_clk); while (s_axi_awready !== 1'b1);
      {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      repeat (gap - 1) @(posedge sys_clk);
    end
    {s_axi_wdata, s_axi_wstrb, s_axi_wvalid} <= {d, s, 1'b1};
    do @(posedge sys_clk);
    while ((s_axi_wready & (s_axi_awready | ~s_axi_awvalid)) !== 1'b1);
    {s_axi_awvalid, s_axi_wvalid, s_axi_awaddr, s_axi_wdata} <= {2'h0, ~a, ~d};
    repeat (dly) @(posedge sys_clk);
    s_axi_bready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // read with a slow or prompt rready
  task rd(input logic [12:0] a, input int dly, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    {s_axi_araddr, s_axi_arprot, s_axi_arvalid} <= {a, ~a[2:0], 1'b1};
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
    repeat (dly) @(posedge sys_clk);
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : csra_axil_master

// ### csra_axil_port.sv
// axi4-lite slave port of the csr block
`include "csra_map.svh"
module csra_axil_port
  import csra_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // write address channel
  input wire logic [`CSRA_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [`CSRA_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [`CSRA_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [`CSRA_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // event output
  output logic irq
);
  typedef struct packed {
    csra_wst_t wst;
    logic aw_have;
    logic [`CSRA_ADDR_W-1:0] aw_addr;
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    csra_rst_t rst;
    logic arready;
    logic [`CSRA_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic irq;
    logic [`CSRA_DATA_W-1:0] evt_cnt;
  } csra_st_t;

  csra_st_t q;
  csra_st_t d;
  // reset synchroniser sits outside the state struct: it runs on the raw reset
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic wr_en;
  logic wr_hit;
  logic rd_hit;
  logic [`CSRA_DATA_W-1:0] rd_data;
  logic [`CSRA_DATA_W-1:0] ctrl;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic prot_unused;

  // protection bits are accepted and deliberately dropped
  // folded into one unread bit so the inputs stay connected
  assign prot_unused = ^{s_axi_awprot, s_axi_arprot};

  // released reset copy; async assert, sync release
  // two stages so a release close to the edge cannot leave half the flops in reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  // only the second stage is read by the rest of the block
  assign rst_n = rst_sync_q[1];

  // handshakes as the master sees them at the edge
  assign aw_hs = s_axi_awvalid && q.awready;
  assign w_hs = s_axi_wvalid && q.wready;
  assign ar_hs = s_axi_arvalid && q.arready;
  // data handshake only lands when the address is here or arrives now
  // limitation: data offered ahead of its address is acknowledged and dropped,
  // so the master must send the address first or in the same cycle
  assign wr_en = w_hs && (q.aw_have || aw_hs);

  // register store; the write address comes from the held copy once taken
  csra_regs csra_regs_i (
    .clk(sys_clk),
    .rst_n(rst_n),
    .wr_en(wr_en),
    .wr_addr(q.aw_have ? q.aw_addr : s_axi_awaddr),
    .wr_data(s_axi_wdata),
    .wr_strb(s_axi_wstrb),
    .wr_hit(wr_hit),
    .rd_addr(s_axi_araddr),
    .evt_count(q.evt_cnt),
    .rd_data(rd_data),
    .rd_hit(rd_hit),
    .ctrl(ctrl)
  );

  // channel sequencing; write and read channels run independently
  always_comb begin
    d = q;
    // irq is a one-cycle pulse, so it falls back every cycle by default
    d.irq = 1'b0;
    // write side
    case (q.wst)
      CSRA_W_IDLE: begin
        // address ready only while none is held or being taken, so one write in flight
        d.awready = !q.aw_have && !aw_hs;
        d.wready = !wr_en;
        if (aw_hs) begin
          d.aw_have = 1'b1;
          d.aw_addr = s_axi_awaddr;
        end
        if (wr_en) begin
          d.aw_have = 1'b0;
          d.awready = 1'b0;
          d.wready = 1'b0;
          d.bvalid = 1'b1;
          d.bresp = wr_hit ? `CSRA_RESP_OKAY : `CSRA_RESP_DECERR;
          d.wst = CSRA_W_RESP;
          // pulse the event output on every write, mapped or not, when enabled
          if (ctrl[`CSRA_CTRL_IRQ_BIT]) begin
            d.irq = 1'b1;
            d.evt_cnt = q.evt_cnt + 32'h0000_0001;
          end
        end
      end
      CSRA_W_RESP: begin
        // response and code stand until the master takes them
        if (s_axi_bready) begin
          d.bvalid = 1'b0;
          d.bresp = `CSRA_RESP_OKAY;
          d.awready = 1'b1;
          d.wready = 1'b1;
          d.wst = CSRA_W_IDLE;
        end
      end
      default: d.wst = CSRA_W_IDLE;
    endcase
    // read side; the mux output is taken at the address handshake
    case (q.rst)
      CSRA_R_IDLE: begin
        if (ar_hs) begin
          d.arready = 1'b0;
          d.rdata = rd_data;
          d.rresp = rd_hit ? `CSRA_RESP_OKAY : `CSRA_RESP_DECERR;
          d.rvalid = 1'b1;
          d.rst = CSRA_R_DATA;
        end
      end
      CSRA_R_DATA: begin
        // data and code stand until the master takes them
        if (s_axi_rready) begin
          d.rvalid = 1'b0;
          d.arready = 1'b1;
          d.rst = CSRA_R_IDLE;
        end
      end
      default: d.rst = CSRA_R_IDLE;
    endcase
  end

  // state register, reset to idle with ready raised
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // write side
      q.wst <= CSRA_W_IDLE;
      q.aw_have <= 1'b0;
      q.aw_addr <= '0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.bresp <= `CSRA_RESP_OKAY;
      q.bvalid <= 1'b0;
      // read side
      q.rst <= CSRA_R_IDLE;
      q.arready <= 1'b1;
      q.rdata <= '0;
      q.rresp <= `CSRA_RESP_OKAY;
      q.rvalid <= 1'b0;
      // event side
      q.irq <= 1'b0;
      q.evt_cnt <= '0;
    end else begin
      // write side
      q.wst <= d.wst;
      q.aw_have <= d.aw_have;
      q.aw_addr <= d.aw_addr;
      q.awready <= d.awready;
      q.wready <= d.wready;
      q.bresp <= d.bresp;
      q.bvalid <= d.bvalid;
      // read side
      q.rst <= d.rst;
      q.arready <= d.arready;
      q.rdata <= d.rdata;
      q.rresp <= d.rresp;
      q.rvalid <= d.rvalid;
      // event side
      q.irq <= d.irq;
      q.evt_cnt <= d.evt_cnt;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign irq = q.irq;
endmodule : csra_axil_port

// ### csra_axil_port_assertions.sv
// protocol assertions of the csr port
`include "csra_map.svh"
module csra_axil_port_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  // event
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // handshake strobes, kept short for the properties
  wire hs_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire hs_r = s_axi_arvalid && s_axi_arready;
  wire hs_a = s_axi_awvalid && s_axi_awready;
  wire hs_d = s_axi_wvalid && s_axi_wready;
  // address taken ahead of its data, cleared when the data is taken
  logic aw_held;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
    end else if (hs_d) begin
      aw_held <= 1'b0;
    end else if (hs_a) begin
      aw_held <= 1'b1;
    end
  end
  property p_wland;
    hs_d && (aw_held || hs_a) |=> s_axi_bvalid && !s_axi_wready;
  endproperty
  a_wland: assert property (p_wland) else $error("held address write not answered");
  property p_wans; hs_w |=> s_axi_bvalid && !s_axi_wready; endproperty
  a_wans: assert property (p_wans) else $error("write answer late");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_bcode; s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h3}; endproperty
  a_bcode: assert property (p_bcode) else $error("bad write code");
  property p_awref; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_awref: assert property (p_awref) else $error("address taken while busy");
  property p_rans; hs_r |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_rdec; s_axi_rvalid && s_axi_rresp == `CSRA_RESP_DECERR |-> s_axi_rdata == 32'h0; endproperty
  a_rdec: assert property (p_rdec) else $error("decode error with data");
  property p_irq; irq |-> $past(hs_d) ##1 !irq; endproperty
  a_irq: assert property (p_irq) else $error("irq not a pulse");
  c_w: cover property (hs_w);
  c_r: cover property (hs_r);
  c_irq: cover property (irq);
  c_split: cover property (aw_held && hs_d);
endmodule : csra_axil_port_chk
bind csra_axil_port csra_axil_port_chk csra_axil_port_chk_i (.*);

// ### csra_map.svh
// constants and address map of the csr access port
`ifndef CSRA_MAP_SVH
`define CSRA_MAP_SVH
`define CSRA_ADDR_W 13
`define CSRA_DATA_W 32
`define CSRA_REG_CTRL 13'h0000
`define CSRA_REG_STAT 13'h0004
`define CSRA_REG_SCR 13'h0008
`define CSRA_REG_EVT 13'h000c
`define CSRA_CTRL_RST 32'h0000_0000
`define CSRA_SCR_RST 32'h0000_0000
`define CSRA_CTRL_IRQ_BIT 0
`define CSRA_RESP_OKAY 2'h0
`define CSRA_RESP_EXOKAY 2'h1
`define CSRA_RESP_SLVERR 2'h2
`define CSRA_RESP_DECERR 2'h3
`endif

// ### csra_pkg.sv
// types of the csr access port
package csra_pkg;
  typedef enum logic [1:0] {
    CSRA_W_IDLE = 2'b00,
    CSRA_W_RESP = 2'b01
  } csra_wst_t;
  typedef enum logic [1:0] {
    CSRA_R_IDLE = 2'b00,
    CSRA_R_DATA = 2'b01
  } csra_rst_t;
endpackage : csra_pkg

// ### csra_regs.sv
// register store with byte strobes
`include "csra_map.svh"
module csra_regs
  import csra_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write side
  input wire logic wr_en,
  input wire logic [`CSRA_ADDR_W-1:0] wr_addr,
  input wire logic [`CSRA_DATA_W-1:0] wr_data,
  input wire logic [3:0] wr_strb,
  output logic wr_hit,
  // read side
  input wire logic [`CSRA_ADDR_W-1:0] rd_addr,
  input wire logic [`CSRA_DATA_W-1:0] evt_count,
  output logic [`CSRA_DATA_W-1:0] rd_data,
  output logic rd_hit,
  // control out
  output logic [`CSRA_DATA_W-1:0] ctrl
);
  typedef struct packed {
    logic [`CSRA_DATA_W-1:0] ctrl;
    logic [`CSRA_DATA_W-1:0] scr;
  } csra_regs_st_t;

  csra_regs_st_t st_q;
  csra_regs_st_t st_d;

  // merge enabled byte lanes into the old value
  function automatic logic [`CSRA_DATA_W-1:0] merge(input logic [`CSRA_DATA_W-1:0] old,
      input logic [`CSRA_DATA_W-1:0] nw, input logic [3:0] strb);
    logic [`CSRA_DATA_W-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : merge

  // writable decode: status and event counter are read only
  assign wr_hit = (wr_addr == `CSRA_REG_CTRL) || (wr_addr == `CSRA_REG_SCR);

  // next state of writable registers
  always_comb begin
    st_d = st_q;
    if (wr_en && wr_addr == `CSRA_REG_CTRL) st_d.ctrl = merge(st_q.ctrl, wr_data, wr_strb);
    if (wr_en && wr_addr == `CSRA_REG_SCR) st_d.scr = merge(st_q.scr, wr_data, wr_strb);
  end

  // registers back to their initial state under reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q.ctrl <= `CSRA_CTRL_RST;
      st_q.scr <= `CSRA_SCR_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // read mux, unmapped flagged as miss
  always_comb begin
    rd_hit = 1'b1;
    case (rd_addr)
      `CSRA_REG_CTRL: rd_data = st_q.ctrl;
      `CSRA_REG_STAT: rd_data = {{(`CSRA_DATA_W-1){1'b0}}, st_q.ctrl[`CSRA_CTRL_IRQ_BIT]};
      `CSRA_REG_SCR: rd_data = st_q.scr;
      `CSRA_REG_EVT: rd_data = evt_count;
      default: begin
        rd_data = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign ctrl = st_q.ctrl;
endmodule : csra_regs
